// file: rtl/rtccal_pkg.sv
// Package for the calendar count and alarm set-point register block.
// Assumes an 8-bit I/O bus with 8-bit addresses and synchronous strobes.
package rtccal_pkg;

    // Register offsets on the I/O bus
    localparam logic [7:0] DOM_OFS     = 8'hE4;
    localparam logic [7:0] MTH_OFS     = 8'hE5;
    localparam logic [7:0] YEAR_OFS    = 8'hE6;
    localparam logic [7:0] HUND_OFS    = 8'hE7;
    localparam logic [7:0] ALARM_SECONDS_VALUE_OFS    = 8'hE8;
    localparam logic [7:0] ALARM_MINUTES_VALUE_OFS    = 8'hE9;
    localparam logic [7:0] ALARM_HOURS_VALUE_OFS    = 8'hEA;
    localparam logic [7:0] AWDAY_OFS   = 8'hEB;

    // Field positions
    localparam int         TENS_MSB    = 7;
    localparam int         TENS_LSB    = 4;
    localparam int         ONES_MSB    = 3;

    // Count limits (binary codes)
    localparam logic [7:0] DOM_FIRST   = 8'h01;
    localparam logic [7:0] MTH_FIRST   = 8'h01;
    localparam logic [7:0] MTH_LAST    = 8'h0C;
    localparam logic [7:0] YEAR_LAST   = 8'h63;
    localparam logic [7:0] HUND_LAST   = 8'h63;
    localparam logic [7:0] UNMAP_READ  = 8'h00;
    localparam logic [3:0] WDAY_RSV    = 4'h0;
    localparam logic [3:0] DIGIT_LAST  = 4'h9;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rtccal_bus_t;

    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hrs;
        logic [3:0] wday;
    } rtccal_time_t;

    typedef struct packed {
        logic [7:0] day_of_month_value;
        logic [7:0] mth;
        logic [7:0] year;
        logic [7:0] hund;
    } rtccal_date_t;

endpackage

// file: rtl/rtccal_incr.sv
// Increments one 8-bit count field with wrap, in binary or two-digit BCD.
// Assumes the input is a legal code in the selected format.
`timescale 1ns/100ps
`default_nettype none
module rtccal_incr (
    // Value and limits, all in the active number format
    input  wire logic [7:0] value_i,
    input  wire logic [7:0] last_i,
    input  wire logic [7:0] first_i,
    input  wire logic       bcd_i,
    // Result
    output logic      [7:0] next_o,
    output logic            wrap_o
);
    always_comb begin
        wrap_o = (value_i == last_i);
        if (wrap_o) begin
            next_o = first_i;
        end else if (bcd_i && (value_i[3:0] == rtccal_pkg::DIGIT_LAST)) begin
            next_o = {4'(value_i[7:4] + 4'h1), 4'h0};
        end else begin
            next_o = 8'(value_i + 8'h01);
        end
    end
endmodule
`default_nettype wire

// file: rtl/rtccal_regs.sv
// Calendar count and alarm set-point registers of a real-time clock.
// Assumes lock and BCD format come from the control register, and that
// second_tick_i pulses once a second with the time-of-day count and
// day_carry_i marks the hour rolling past 23 on that same tick.
// Summary of operation
// - Day-of-month counts from one, never zero, in either format.
// - Day, month, year, century counts are not reset.
// - Count register writes ignored while locked, taken while unlocked; reads always.
// - Binary day-of-month uses the whole byte, one to thirty-one.
// - BCD day-of-month: tens 0-3 upper nibble, ones 0-9 lower.
// - Binary month counts one to twelve.
// - BCD month: tens 0-1 in bits 7:4, ones in 3:0.
// - Binary year counts zero to ninety-nine.
// - BCD year holds two digits, tens in upper nibble.
// - Century counts 0-99 binary, or two BCD digits.
// - Alarm seconds, minutes, hours always writable, kept through reset.
// - Alarm seconds 0-59; BCD tens 0-5 in upper nibble.
// - Alarm minutes 0-59; BCD tens upper, ones lower.
// - Alarm hours hold zero to twenty-three.
// - BCD alarm hours tens 0-2 in bits 7:4.
// - Alarm weekday bits 7:4 read zero; 3:0 kept, lock-gated writes.
// - Alarm weekday field is low nibble, one to seven.
// - Alarm set-points compared with count on each one-second advance.
// - BCD format makes counts and alarm set-points BCD.
// - Unlocked stops counting and takes writes; locked counts and refuses count and weekday writes.
`timescale 1ns/100ps
`default_nettype none
module rtccal_regs (
    // Clock, reset, enable
    input  wire logic                     clk_i,
    input  wire logic                     reset_i,
    input  wire logic                     ce_i,
    // I/O bus
    input  wire rtccal_pkg::rtccal_bus_t  bus_i,
    output logic                    [7:0] rdata_o,
    output logic                          hit_o,
    // Control register bits
    input  wire logic                     unlock_i,
    input  wire logic                     bcd_i,
    // Time-of-day count
    input  wire logic                     second_tick_i,
    input  wire logic                     day_carry_i,
    input  wire rtccal_pkg::rtccal_time_t now_i,
    // Alarm results and calendar date
    output logic                    [3:0] alarm_match_o,
    output logic                          compare_o,
    output rtccal_pkg::rtccal_date_t      date_o
);
    // Count and set-point state, deliberately without reset
    logic [7:0] dom_reg,   dom_next;
    logic [7:0] mth_reg,   mth_next;
    logic [7:0] year_reg,  year_next;
    logic [7:0] hund_reg,  hund_next;
    logic [7:0] alarm_seconds_value_reg,  alarm_seconds_value_next;
    logic [7:0] alarm_minutes_value_reg,  alarm_minutes_value_next;
    logic [7:0] alarm_hours_value_reg,  alarm_hours_value_next;
    logic [3:0] awday_reg, awday_next;
    // Bus and compare outputs, reset
    logic [7:0] rdata_reg, rdata_next;
    logic [3:0] match_reg, match_next;
    logic       cmp_reg,   cmp_next;
    logic       unlock_d_reg;

    logic       advance;
    logic       wr_en;
    logic       cnt_wr;
    logic       dom_wrap, mth_wrap, year_wrap;
    logic [7:0] dom_inc, mth_inc, year_inc, hund_inc;
    logic [7:0] dom_last, mth_last, year_last, hund_last;
    logic [7:0] mth_bin;
    logic       leap;

    assign advance = second_tick_i && day_carry_i && !unlock_i;
    assign wr_en   = bus_i.wr && ce_i;
    assign cnt_wr  = wr_en && unlock_i;

    // Month as binary for the month-length table
    assign mth_bin = bcd_i ? 8'(mth_reg[7:4] * 4'hA + mth_reg[3:0]) : mth_reg;
    // Leap year by year count only; divisible by four.
    // In BCD, year mod 4 is twice the tens parity plus the ones digit, taken mod 4.
    assign leap    = bcd_i ? (2'({year_reg[4], 1'b0} + year_reg[1:0]) == 2'h0)
                           : (year_reg[1:0] == 2'h0);

    always_comb begin
        unique case (mth_bin)
            8'h02:   dom_last = leap ? 8'h1D : 8'h1C;
            8'h04, 8'h06, 8'h09, 8'h0B: dom_last = 8'h1E;
            default: dom_last = 8'h1F;
        endcase
        if (bcd_i) begin
            dom_last = {4'(dom_last / 8'h0A), 4'(dom_last % 8'h0A)};
        end
        mth_last  = bcd_i ? 8'h12 : rtccal_pkg::MTH_LAST;
        year_last = bcd_i ? 8'h99 : rtccal_pkg::YEAR_LAST;
        hund_last = bcd_i ? 8'h99 : rtccal_pkg::HUND_LAST;
    end

    rtccal_incr u_dom (
        .value_i (dom_reg),
        .last_i  (dom_last),
        .first_i (rtccal_pkg::DOM_FIRST),
        .bcd_i   (bcd_i),
        .next_o  (dom_inc),
        .wrap_o  (dom_wrap)
    );
    rtccal_incr u_mth (
        .value_i (mth_reg),
        .last_i  (mth_last),
        .first_i (rtccal_pkg::MTH_FIRST),
        .bcd_i   (bcd_i),
        .next_o  (mth_inc),
        .wrap_o  (mth_wrap)
    );
    rtccal_incr u_year (
        .value_i (year_reg),
        .last_i  (year_last),
        .first_i (8'h00),
        .bcd_i   (bcd_i),
        .next_o  (year_inc),
        .wrap_o  (year_wrap)
    );
    rtccal_incr u_hund (
        .value_i (hund_reg),
        .last_i  (hund_last),
        .first_i (8'h00),
        .bcd_i   (bcd_i),
        .next_o  (hund_inc),
        .wrap_o  ()
    );

    // Calendar count next values
    always_comb begin
        dom_next  = dom_reg;
        mth_next  = mth_reg;
        year_next = year_reg;
        hund_next = hund_reg;
        if (ce_i && advance) begin
            dom_next = dom_inc;
            if (dom_wrap) begin
                mth_next = mth_inc;
                if (mth_wrap) begin
                    year_next = year_inc;
                    if (year_wrap) begin
                        hund_next = hund_inc;
                    end
                end
            end
        end
        if (cnt_wr) begin
            unique case (bus_i.addr)
                rtccal_pkg::DOM_OFS:  dom_next  = bus_i.wdata;
                rtccal_pkg::MTH_OFS:  mth_next  = bus_i.wdata;
                rtccal_pkg::YEAR_OFS: year_next = bus_i.wdata;
                rtccal_pkg::HUND_OFS: hund_next = bus_i.wdata;
                default: ;
            endcase
        end
    end

    // Alarm set-point next values
    always_comb begin
        alarm_seconds_value_next  = alarm_seconds_value_reg;
        alarm_minutes_value_next  = alarm_minutes_value_reg;
        alarm_hours_value_next  = alarm_hours_value_reg;
        awday_next = awday_reg;
        if (wr_en) begin
            unique case (bus_i.addr)
                rtccal_pkg::ALARM_SECONDS_VALUE_OFS:  alarm_seconds_value_next = bus_i.wdata;
                rtccal_pkg::ALARM_MINUTES_VALUE_OFS:  alarm_minutes_value_next = bus_i.wdata;
                rtccal_pkg::ALARM_HOURS_VALUE_OFS:  alarm_hours_value_next = bus_i.wdata;
                rtccal_pkg::AWDAY_OFS: begin
                    if (unlock_i) begin
                        awday_next = bus_i.wdata[rtccal_pkg::ONES_MSB:0];
                    end
                end
                default: ;
            endcase
        end
    end

    // Register read and decode
    always_comb begin
        hit_o      = 1'b1;
        rdata_next = rdata_reg;
        unique case (bus_i.addr)
            rtccal_pkg::DOM_OFS:   rdata_next = dom_reg;
            rtccal_pkg::MTH_OFS:   rdata_next = mth_reg;
            rtccal_pkg::YEAR_OFS:  rdata_next = year_reg;
            rtccal_pkg::HUND_OFS:  rdata_next = hund_reg;
            rtccal_pkg::ALARM_SECONDS_VALUE_OFS:  rdata_next = alarm_seconds_value_reg;
            rtccal_pkg::ALARM_MINUTES_VALUE_OFS:  rdata_next = alarm_minutes_value_reg;
            rtccal_pkg::ALARM_HOURS_VALUE_OFS:  rdata_next = alarm_hours_value_reg;
            rtccal_pkg::AWDAY_OFS: rdata_next = {rtccal_pkg::WDAY_RSV, awday_reg};
            default: begin
                hit_o      = 1'b0;
                rdata_next = rtccal_pkg::UNMAP_READ;
            end
        endcase
        if (!(bus_i.rd && ce_i)) begin
            rdata_next = rdata_reg;
        end
    end

    // Alarm compare on each second while locked, and on a fresh lock
    always_comb begin
        match_next = match_reg;
        cmp_next   = 1'b0;
        if (ce_i && ((second_tick_i && !unlock_i) || (unlock_d_reg && !unlock_i))) begin
            match_next = {now_i.wday == awday_reg,
                          now_i.hrs  == alarm_hours_value_reg,
                          now_i.min  == alarm_minutes_value_reg,
                          now_i.sec  == alarm_seconds_value_reg};
            cmp_next   = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        dom_reg   <= dom_next;
        mth_reg   <= mth_next;
        year_reg  <= year_next;
        hund_reg  <= hund_next;
        alarm_seconds_value_reg  <= alarm_seconds_value_next;
        alarm_minutes_value_reg  <= alarm_minutes_value_next;
        alarm_hours_value_reg  <= alarm_hours_value_next;
        awday_reg <= awday_next;
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_reg    <= 8'h00;
            match_reg    <= 4'h0;
            cmp_reg      <= 1'b0;
            unlock_d_reg <= 1'b0;
        end else if (ce_i) begin
            rdata_reg    <= rdata_next;
            match_reg    <= match_next;
            cmp_reg      <= cmp_next;
            unlock_d_reg <= unlock_i;
        end
    end

    assign rdata_o       = rdata_reg;
    assign alarm_match_o = match_reg;
    assign compare_o     = cmp_reg;
    assign date_o        = '{day_of_month_value: dom_reg, mth: mth_reg, year: year_reg, hund: hund_reg};
endmodule
`default_nettype wire

// file: bench/rtccal_props.sv
// Checker for the calendar count and alarm set-point register block.
// Sees only the ports of rtccal_regs; bound from the testbench top file.
`timescale 1ns/100ps
`default_nettype none
module rtccal_props (
    // Clock and control
    input wire logic                     clk_i,
    input wire logic                     reset_i,
    input wire logic                     ce_i,
    input wire logic                     unlock_i,
    input wire logic                     bcd_i,
    input wire logic                     second_tick_i,
    input wire logic                     day_carry_i,
    // Bus and time-of-day
    input wire rtccal_pkg::rtccal_bus_t  bus_i,
    input wire rtccal_pkg::rtccal_time_t now_i,
    // Results
    input wire logic               [7:0] rdata_o,
    input wire logic                     hit_o,
    input wire logic               [3:0] alarm_match_o,
    input wire logic                     compare_o,
    input wire rtccal_pkg::rtccal_date_t date_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    sequence s_wr(logic [7:0] a);
        ce_i && bus_i.wr && bus_i.addr == a;
    endsequence
    sequence s_rd(logic [7:0] a);
        ce_i && bus_i.rd && bus_i.addr == a;
    endsequence
    sequence s_day;
        ce_i && second_tick_i && day_carry_i && !unlock_i;
    endsequence

    a_dom_locked: assert property (s_wr(8'hE4) ##0 !unlock_i && !second_tick_i |=>
        $stable(date_o.day_of_month_value)) else $error("locked day write changed the count");
    a_dom_open: assert property (s_wr(8'hE4) ##0 unlock_i |=>
        date_o.day_of_month_value == $past(bus_i.wdata)) else $error("unlocked day write lost");
    a_open_frozen: assert property (unlock_i && !bus_i.wr |=> $stable(date_o))
        else $error("count moved while unlocked");
    a_ce_frozen: assert property (!ce_i |=> $stable(date_o) && $stable(rdata_o))
        else $error("state moved with enable low");
    a_day_range: assert property (s_day ##0 !bcd_i |=> date_o.day_of_month_value inside {[8'h01:8'h1F]}
        && date_o.mth inside {[8'h01:8'h0C]} && date_o.year <= 8'h63)
        else $error("binary date out of range after advance");
    a_tick_cmp: assert property (ce_i && second_tick_i && !unlock_i |-> ##[1:2] compare_o)
        else $error("no compare after tick");
    a_rd_stands: assert property (!(ce_i && bus_i.rd) |=> $stable(rdata_o))
        else $error("read data changed without read");
    a_wday_rsv: assert property (s_rd(8'hEB) |=> rdata_o[7:4] == 4'h0)
        else $error("weekday reserved bits not zero");
    a_alarm_back: assert property (s_wr(8'hE8) ##2 s_rd(8'hE8) |=>
        rdata_o == $past(bus_i.wdata, 3)) else $error("alarm seconds readback wrong");
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Testbench for the calendar count and alarm set-point register block.
// Drives bus, lock, format and tick inputs at the falling clock edge.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic                     clk_i = 1'b0;
    logic                     reset_i = 1'b1;
    logic                     ce_i = 1'b1;
    logic                     unlock_i = 1'b1;
    logic                     bcd_i = 1'b0;
    logic                     second_tick_i = 1'b0;
    logic                     day_carry_i = 1'b0;
    rtccal_pkg::rtccal_bus_t  bus_i = '0;
    rtccal_pkg::rtccal_time_t now_i = '0;
    logic               [7:0] rdata_o;
    logic                     hit_o;
    logic               [3:0] alarm_match_o;
    logic                     compare_o;
    rtccal_pkg::rtccal_date_t date_o;
    int                       n_mismatch = 0;
    int                       checks_done = 0;
    int                       cycles = 0;
    logic              [31:0] bcd_in [4] = '{32'h28020319, 32'h31129919, 32'h28020419, 32'h09090909};
    logic              [31:0] bcd_out [4] = '{32'h01030319, 32'h01010020, 32'h29020419, 32'h10090909};

    always #25 clk_i = ~clk_i;

    rtccal_regs DUT (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .bus_i(bus_i),
        .rdata_o(rdata_o), .hit_o(hit_o), .unlock_i(unlock_i), .bcd_i(bcd_i),
        .second_tick_i(second_tick_i), .day_carry_i(day_carry_i), .now_i(now_i),
        .alarm_match_o(alarm_match_o), .compare_o(compare_o), .date_o(date_o));

    task automatic test_done;
        $display("Compares %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Bus tasks are entered and left at a falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_i = '{1'b1, 1'b0, a, d};
        @(negedge clk_i);
        bus_i.wr = 1'b0;
        @(negedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        bus_i = '{1'b0, 1'b1, a, bus_i.wdata};
        #5;
        chk({31'h0, hit_o}, {31'h0, (a >= rtccal_pkg::DOM_OFS && a <= rtccal_pkg::AWDAY_OFS)});
        @(negedge clk_i);
        bus_i.rd = 1'b0;
        @(negedge clk_i);
        chk({24'h0, rdata_o}, {24'h0, exp});
    endtask

    task automatic tick(input logic dc);
        second_tick_i = 1'b1;
        day_carry_i = dc;
        @(negedge clk_i);
        second_tick_i = 1'b0;
        day_carry_i = 1'b0;
        repeat (3) @(negedge clk_i);
    endtask

    task automatic set_date(input logic [31:0] v);
        unlock_i = 1'b1;
        wr(8'hE4, v[31:24]);
        wr(8'hE5, v[23:16]);
        wr(8'hE6, v[15:8]);
        wr(8'hE7, v[7:0]);
        unlock_i = 1'b0;
        @(negedge clk_i);
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            test_done;
        end
    end

    initial begin
        // Counts and weekday have no reset value: load them while reset holds
        bus_i = '{1'b1, 1'b0, 8'hE4, 8'h01};
        @(negedge clk_i);
        bus_i.addr = 8'hE5;
        @(negedge clk_i);
        bus_i.addr = 8'hE6;
        bus_i.wdata = 8'h00;
        @(negedge clk_i);
        bus_i.addr = 8'hE7;
        @(negedge clk_i);
        bus_i.addr = 8'hEB;
        bus_i.wdata = 8'hF7;
        @(negedge clk_i);
        bus_i.wr = 1'b0;
        unlock_i = 1'b0;
        @(negedge clk_i);
        reset_i = 1'b0;
        @(negedge clk_i);
        wr(8'hEB, 8'hF7);
        set_date(32'h1F0C6305);
        rd(8'hE4, 8'h1F);
        rd(8'hE5, 8'h0C);
        rd(8'hE6, 8'h63);
        // Locked: count and weekday writes refused, alarm writes taken
        wr(8'hE4, 8'h00);
        rd(8'hE4, 8'h1F);
        wr(8'hEB, 8'h03);
        rd(8'hEB, 8'h07);
        wr(8'hE8, 8'h3B);
        rd(8'hE8, 8'h3B);
        wr(8'hE9, 8'h3B);
        rd(8'hE9, 8'h3B);
        wr(8'hEA, 8'h17);
        rd(8'hEA, 8'h17);
        rd(8'hEC, 8'h00);
        now_i = '{8'h3B, 8'h3B, 8'h17, 4'h7};
        tick(1'b0);
        chk({28'h0, alarm_match_o}, 32'hF);
        now_i.sec = 8'h00;
        tick(1'b0);
        chk({28'h0, alarm_match_o}, 32'hE);
        tick(1'b1);
        chk(date_o, 32'h01010006);
        ce_i = 1'b0;
        tick(1'b1);
        ce_i = 1'b1;
        chk(date_o, 32'h01010006);
        bcd_i = 1'b1;
        for (int i = 0; i < 4; i++) begin
            set_date(bcd_in[i]);
            tick(1'b1);
            chk(date_o, bcd_out[i]);
        end
        // Second reset keeps counts and alarm weekday
        reset_i = 1'b1;
        repeat (2) @(negedge clk_i);
        chk({24'h0, rdata_o}, 32'h0);
        reset_i = 1'b0;
        @(negedge clk_i);
        chk(date_o, 32'h10090909);
        rd(8'hEB, 8'h07);
        rd(8'hE8, 8'h3B);
        test_done;
    end
endmodule

bind rtccal_regs rtccal_props u_props (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
    .unlock_i(unlock_i), .bcd_i(bcd_i), .second_tick_i(second_tick_i),
    .day_carry_i(day_carry_i), .bus_i(bus_i), .now_i(now_i), .rdata_o(rdata_o),
    .hit_o(hit_o), .alarm_match_o(alarm_match_o), .compare_o(compare_o), .date_o(date_o));
`default_nettype wire
